// *** src/csa_pkg.sv ***
// Constants, alert bit layout and check-byte function for the serial port.
// Assumes one 50 MHz clock; all pin inputs except adc_rdy_i and din_comp_i are synchronised in the port.
package csa_pkg;
    // ****************************************
    // Frame layout
    // ****************************************
    localparam logic [5:0] CNT_FRAME = 6'h20;
    localparam logic [5:0] CNT_MAX = 6'h3f;
    localparam logic [4:0] PTR_FIRST = 5'h1f;
    localparam logic [4:0] PTR_STREAM = 5'h17;
    localparam logic [7:0] CRC_POLY = 8'h07;
    localparam logic [7:0] CRC_INIT = 8'h00;
    // ****************************************
    // Register map
    // ****************************************
    localparam logic [6:0] ADDR_NOP = 7'h00;
    localparam logic [6:0] ADDR_RD_SEL = 7'h01;
    localparam logic [6:0] ADDR_THERM = 7'h02;
    localparam logic [6:0] ADDR_MASK = 7'h03;
    localparam logic [6:0] ADDR_STATUS = 7'h04;
    localparam logic [6:0] ADDR_LIVE = 7'h05;
    localparam int RS_INFO_BIT = 8;
    localparam int RS_AUTO_BIT = 9;
    localparam int TR_EN_BIT = 0;
    localparam logic [9:0] RD_SEL_RST = 10'h000;
    localparam logic [0:0] THERMAL_RESET_CONTROL_VAL = 1'h0;
    // ****************************************
    // Alert bits
    // ****************************************
    localparam int AL_W = 8;
    localparam int SUP_W = 4;
    localparam int AL_RESET = 0;
    localparam int AL_CRC = 1;
    localparam int AL_CNT = 2;
    localparam int AL_HOT = 3;
    localparam int AL_SUP = 4;
    localparam logic [7:0] ALERT_RST = 8'h01;
    localparam logic [7:0] MASK_RST = 8'h00;
    // Pin sync reset: select and clock idle high
    localparam logic [8:0] SYNC_RST = 9'h003;

    function automatic logic [7:0] csa_crc8(input logic [23:0] d);
        logic [7:0] c;
        c = CRC_INIT;
        for (int i = 23; i >= 0; i--)
        begin
            c = (c[7] ^ d[i]) ? ({c[6:0], 1'b0} ^ CRC_POLY) : {c[6:0], 1'b0};
        end
        return c;
    endfunction : csa_crc8
endpackage : csa_pkg

// *** src/csa_sync3.sv ***
// Three-flop pin synchroniser with agreement filter.
// Assumes inputs asynchronous to sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module csa_sync3 #(
    parameter int W = 1,
    parameter logic [W-1:0] RST = '0
) (
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic [W-1:0] async_i,
    output logic [W-1:0] clean_o
);
    logic [W-1:0] s1_q, s2_q, s3_q, out_q;

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            s1_q <= RST;
            s2_q <= RST;
            s3_q <= RST;
        end
        else
        begin
            s1_q <= async_i;
            s2_q <= s1_q;
            s3_q <= s2_q;
        end
    end

    // Change accepted only once flops two and three agree
    for (genvar i = 0; i < W; i++)
    begin : g_agree
        always_ff @(posedge sys_clk_i or negedge nrst_i)
        begin
            if (!nrst_i)
                out_q[i] <= RST[i];
            else if (s2_q[i] == s3_q[i])
                out_q[i] <= s3_q[i];
        end
    end

    assign clean_o = out_q;
endmodule : csa_sync3
`default_nettype wire

// *** src/csa_alert.sv ***
// Latched alert flags with write-one clear, mask and alert pin.
// Assumes set, clear and mask come from logic on sys_clk_i.
`timescale 1ns/1ps
`default_nettype none
module csa_alert
    import csa_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic srst_i,
    input wire logic [AL_W-1:0] set_i,
    input wire logic [AL_W-1:0] clr_i,
    input wire logic [AL_W-1:0] mask_i,
    output logic [AL_W-1:0] latched_o,
    output logic alert_n_o
);
    logic [AL_W-1:0] lat_q, lat_d;
    logic alert_n_q;
    wire [AL_W-1:0] clr_only = clr_i & ~set_i;

    // Set wins over a clear in the same cycle
    assign lat_d = srst_i ? ALERT_RST : ((lat_q & ~clr_i) | set_i);

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            lat_q <= ALERT_RST;
            alert_n_q <= ~|(ALERT_RST & ~MASK_RST);
        end
        else
        begin
            lat_q <= lat_d;
            alert_n_q <= ~|(lat_d & ~mask_i);
        end
    end

    assign latched_o = lat_q;
    assign alert_n_o = alert_n_q;

    AST_ALERT_LOW: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (|(lat_q & ~mask_i) && clr_i == '0 && !srst_i && $stable(mask_i)) |=> !alert_n_o)
        else $error("alert pin not low with unmasked flag");
    AST_ALERT_FREE: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (lat_q == '0 && set_i == '0 && !srst_i) |=> alert_n_o)
        else $error("alert pin low with no flags");
    AST_W1C: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!srst_i && (clr_only & lat_q) != '0) |=> (lat_q & $past(clr_only)) == '0)
        else $error("flag not cleared by write one");
    AST_SET_WINS: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (!srst_i && set_i != '0) |=> (lat_q & $past(set_i)) == $past(set_i))
        else $error("event lost");
endmodule : csa_alert
`default_nettype wire

// *** src/csa_spi_port.sv ***
// Serial register port with check byte, clock counting, readback,
// streaming, auto readback and alert flag registers.
// Assumes pins asynchronous to sys_clk_i; sclk well below clock / 8.
`timescale 1ns/1ps
`default_nettype none
module csa_spi_port
    import csa_pkg::*;
(
    input wire logic sys_clk_i,
    input wire logic nrst_i,
    input wire logic sclk_i,
    input wire logic sync_n_i,
    input wire logic sdi_i,
    output logic sdo_o,
    output logic alert_n_o,
    input wire logic die_hot_i,
    input wire logic die_crit_i,
    input wire logic [SUP_W-1:0] supply_low_i,
    input wire logic adc_rdy_i,
    input wire logic [3:0] din_comp_i,
    output logic thermal_reset_o
);
    // ****************************************
    // Pin synchronisation and edges
    // ****************************************
    logic [8:0] raw, clean;
    logic sclk_s, cs_n_s, sdi_s, hot_s, crit_s;
    logic [SUP_W-1:0] sup_s;
    logic sclk_p_q, cs_p_q;

    assign raw = {supply_low_i, die_crit_i, die_hot_i, sdi_i, sync_n_i, sclk_i};

    csa_sync3 #(
        .W(9),
        .RST(SYNC_RST)
    ) u_sync (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .async_i(raw),
        .clean_o(clean)
    );

    assign sclk_s = clean[0];
    assign cs_n_s = clean[1];
    assign sdi_s = clean[2];
    assign hot_s = clean[3];
    assign crit_s = clean[4];
    assign sup_s = clean[8:5];

    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            sclk_p_q <= 1'b1;
            cs_p_q <= 1'b1;
        end
        else
        begin
            sclk_p_q <= sclk_s;
            cs_p_q <= cs_n_s;
        end
    end

    wire cs_fall = cs_p_q & ~cs_n_s;
    wire cs_rise = ~cs_p_q & cs_n_s;
    wire sck_fall = sclk_p_q & ~sclk_s & ~cs_n_s;
    wire sck_rise = ~sclk_p_q & sclk_s & ~cs_n_s;

    // ****************************************
    // State
    // ****************************************
    logic srst_q;
    logic [31:0] rx_q, tx_q, next_word, first_word;
    logic [5:0] fall_cnt_q;
    logic [4:0] ptr_q;
    logic sdo_q, wrap_q, rd_act_q, rd_pend_q;
    logic [9:0] rd_sel_q;
    logic [0:0] therm_q;
    logic [AL_W-1:0] mask_q, alert_lat, alert_set, alert_clr, live;
    logic [6:0] stream_addr_q;

    wire [6:0] sel_addr = rd_sel_q[6:0];
    wire info_sel = rd_sel_q[RS_INFO_BIT];
    wire auto_en = rd_sel_q[RS_AUTO_BIT];
    wire rd_act_d = auto_en | rd_pend_q;

    // ****************************************
    // Frame decode
    // ****************************************
    wire [6:0] rx_addr = rx_q[30:24];
    wire [15:0] rx_data = rx_q[23:8];
    wire crc_ok = csa_crc8(rx_q[31:8]) == rx_q[7:0];
    wire len_ok = fall_cnt_q == CNT_FRAME;
    // Streaming once a read frame sees more than one word of clocks
    wire strm = rd_act_q && (fall_cnt_q > CNT_FRAME);
    wire cnt_ok = strm ? (wrap_q && ptr_q == PTR_STREAM) : len_ok;
    // A full word of clocks excludes streaming, so no write then
    wire wr_ok = cs_rise && len_ok && crc_ok;
    wire wr_rd_sel = wr_ok && rx_addr == ADDR_RD_SEL;
    wire wr_therm = wr_ok && rx_addr == ADDR_THERM;
    wire wr_mask = wr_ok && rx_addr == ADDR_MASK;
    wire wr_status = wr_ok && rx_addr == ADDR_STATUS;

    // ****************************************
    // Readback word
    // ****************************************
    function automatic logic [15:0] reg_val(input logic [6:0] a);
        logic [15:0] v;
        v = 16'h0000;
        case (a)
            ADDR_RD_SEL: v = {6'h00, rd_sel_q};
            ADDR_THERM: v = {15'h0000, therm_q};
            ADDR_MASK: v = {8'h00, mask_q};
            ADDR_STATUS: v = {8'h00, alert_lat};
            ADDR_LIVE: v = {8'h00, live};
            default: v = 16'h0000;
        endcase
        return v;
    endfunction : reg_val

    function automatic logic [31:0] rd_word(input logic [6:0] a);
        logic [23:0] up;
        logic [6:0] hdr;
        hdr = info_sel ? {1'b0, ~alert_n_o, adc_rdy_i, din_comp_i} : a;
        up = {1'b1, hdr, reg_val(a)};
        return {up, csa_crc8(up)};
    endfunction : rd_word

    wire [6:0] next_addr = stream_addr_q + 7'h01;
    always_comb next_word = rd_word(next_addr);
    always_comb first_word = rd_act_d ? rd_word(sel_addr) : 32'h00000000;

    // ****************************************
    // Receive shifter and edge count
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rx_q <= 32'h00000000;
            fall_cnt_q <= 6'h00;
        end
        else if (srst_q || cs_fall)
        begin
            rx_q <= 32'h00000000;
            fall_cnt_q <= 6'h00;
        end
        else if (sck_fall)
        begin
            rx_q <= {rx_q[30:0], sdi_s};
            fall_cnt_q <= (fall_cnt_q == CNT_MAX) ? CNT_MAX : fall_cnt_q + 6'h01;
        end
    end

    // ****************************************
    // Transmit shifter and streaming
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            tx_q <= 32'h00000000;
            sdo_q <= 1'b0;
            ptr_q <= PTR_FIRST;
            wrap_q <= 1'b0;
            rd_act_q <= 1'b0;
            stream_addr_q <= 7'h00;
        end
        else if (srst_q)
        begin
            tx_q <= 32'h00000000;
            sdo_q <= 1'b0;
            ptr_q <= PTR_FIRST;
            wrap_q <= 1'b0;
            rd_act_q <= 1'b0;
            stream_addr_q <= 7'h00;
        end
        else if (cs_fall)
        begin
            tx_q <= first_word;
            sdo_q <= rd_act_d;
            ptr_q <= PTR_FIRST;
            wrap_q <= 1'b0;
            rd_act_q <= rd_act_d;
            stream_addr_q <= sel_addr;
        end
        else if (sck_rise)
        begin
            if (ptr_q == 5'h00)
            begin
                // Word done: preload the next address
                wrap_q <= 1'b1;
                ptr_q <= PTR_STREAM;
                stream_addr_q <= next_addr;
                tx_q <= rd_act_q ? next_word : 32'h00000000;
                sdo_q <= rd_act_q & next_word[PTR_STREAM];
            end
            else
            begin
                ptr_q <= ptr_q - 5'h01;
                sdo_q <= tx_q[ptr_q - 5'h01];
            end
        end
        else if (cs_rise)
        begin
            sdo_q <= 1'b0;
        end
    end

    assign sdo_o = sdo_q;

    // ****************************************
    // Registers written over the port
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
        begin
            rd_sel_q <= RD_SEL_RST;
            therm_q <= THERMAL_RESET_CONTROL_VAL;
            mask_q <= MASK_RST;
            rd_pend_q <= 1'b0;
        end
        else if (srst_q)
        begin
            rd_sel_q <= RD_SEL_RST;
            therm_q <= THERMAL_RESET_CONTROL_VAL;
            mask_q <= MASK_RST;
            rd_pend_q <= 1'b0;
        end
        else
        begin
            if (wr_rd_sel)
                rd_sel_q <= rx_data[9:0];
            if (wr_therm)
                therm_q <= rx_data[TR_EN_BIT];
            if (wr_mask)
                mask_q <= rx_data[7:0];
            // A select write arms the next frame's readback
            if (cs_rise)
                rd_pend_q <= wr_rd_sel;
        end
    end

    // ****************************************
    // Thermal reset
    // ****************************************
    always_ff @(posedge sys_clk_i or negedge nrst_i)
    begin
        if (!nrst_i)
            srst_q <= 1'b0;
        else
            srst_q <= therm_q[TR_EN_BIT] & crit_s & ~srst_q;
    end

    assign thermal_reset_o = srst_q;

    // ****************************************
    // Alert sources
    // ****************************************
    always_comb
    begin
        alert_set = '0;
        alert_set[AL_CRC] = cs_rise & len_ok & ~crc_ok;
        alert_set[AL_CNT] = cs_rise & ~cnt_ok;
        alert_set[AL_HOT] = hot_s;
        alert_set[AL_SUP +: SUP_W] = sup_s;
    end

    assign alert_clr = wr_status ? rx_data[7:0] : '0;

    always_comb
    begin
        live = '0;
        live[AL_HOT] = hot_s;
        live[AL_SUP +: SUP_W] = sup_s;
    end

    csa_alert u_alert (
        .sys_clk_i(sys_clk_i),
        .nrst_i(nrst_i),
        .srst_i(srst_q),
        .set_i(alert_set),
        .clr_i(alert_clr),
        .mask_i(mask_q),
        .latched_o(alert_lat),
        .alert_n_o(alert_n_o)
    );

    // ****************************************
    // Checks
    // ****************************************
    sequence s_open_read;
        cs_fall && rd_act_d && !srst_q;
    endsequence
    sequence s_close;
        cs_rise && !srst_q;
    endsequence

    AST_BIT31: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_open_read |=> sdo_o && ptr_q == PTR_FIRST)
        else $error("bit 31 not driven high at select");
    AST_SHIFT_IN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (sck_fall && !srst_q && !cs_fall) |=> rx_q[0] == $past(sdi_s))
        else $error("serial input not shifted in");
    AST_CRC_FLAG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (s_close and (len_ok && !crc_ok)) |=> alert_lat[AL_CRC] ##1 !alert_n_o || mask_q[AL_CRC])
        else $error("check mismatch not flagged");
    AST_CNT_FLAG: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (s_close and !cnt_ok) |=> alert_lat[AL_CNT])
        else $error("clock count error not flagged");
    AST_NO_STREAM_WR: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (s_close and strm) |=> $stable(mask_q) && $stable(rd_sel_q) && $stable(therm_q))
        else $error("register written while streaming");
    AST_STREAM_STEP: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (sck_rise && ptr_q == 5'h00 && !srst_q && !cs_fall) |=>
        stream_addr_q == $past(next_addr) && ptr_q == PTR_STREAM)
        else $error("stream did not step address");
    AST_AUTO_RETURN: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (cs_fall && !srst_q) |=> stream_addr_q == $past(sel_addr))
        else $error("frame not restarted at target");
    AST_ECHO: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (s_open_read and !info_sel) |=> tx_q[30:24] == $past(sel_addr) && tx_q[31])
        else $error("address echo wrong");
    AST_TX_CRC: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        s_open_read |=> tx_q[7:0] == csa_crc8(tx_q[31:8]))
        else $error("outgoing check byte wrong");
    AST_THERM: assert property (@(posedge sys_clk_i) disable iff (!nrst_i)
        (therm_q[TR_EN_BIT] && crit_s && !srst_q) |=> thermal_reset_o ##1 alert_lat[AL_RESET])
        else $error("thermal reset not taken");
endmodule : csa_spi_port
`default_nettype wire

// *** tb/csa_host_model.sv ***
// Host serial controller model: drives clock, select and data in frames.
// Assumes the bench clock paces it; one serial half period is four clocks.
`timescale 1ns/1ps
`default_nettype none
module csa_host_model (
    input wire logic sys_clk_i,
    output logic sclk_o,
    output logic sync_n_o,
    output logic sdi_o,
    input wire logic sdo_i
);
    initial
    begin
        sclk_o = 1'b1;
        sync_n_o = 1'b1;
        sdi_o = 1'b0;
    end

    // ****************************************
    // Check byte and frame timing
    // ****************************************
    function automatic logic [7:0] crc8(input logic [23:0] d);
        logic [7:0] c;
        c = 8'h00;
        for (int i = 23; i >= 0; i--)
        begin
            c = {c[6:0], 1'b0} ^ ((c[7] ^ d[i]) ? 8'h07 : 8'h00);
        end
        return c;
    endfunction : crc8

    task automatic half();
        repeat (4) @(posedge sys_clk_i);
        #1;
    endtask : half

    // Bits past 32 come from fill; rx keeps every bit sampled, last in bit 0
    task automatic xfer(input logic [31:0] w, input int nbits, input logic [31:0] fill,
                        output logic [127:0] rx);
        rx = '0;
        sync_n_o = 1'b0;
        for (int i = 0; i < nbits; i++)
        begin
            sdi_o = (i < 32) ? w[31 - i] : fill[i % 32];
            half();
            sclk_o = 1'b0;
            half();
            // Sampled just before the rise, after the device's late launch
            rx = {rx[126:0], sdo_i};
            sclk_o = 1'b1;
        end
        half();
        sync_n_o = 1'b1;
        // Released data line must not look like a held bit
        sdi_o = ~sdi_o;
        repeat (4) half();
    endtask : xfer
endmodule : csa_host_model
`default_nettype wire

// *** tb/csa_spi_port_tb_top.sv ***
// Self-checking bench for the serial port and its alert flags.
// Assumes csa_pkg and the host model; register map as chosen by the design.
`timescale 1ns/1ps
`default_nettype none
module csa_spi_port_tb_top;
    import csa_pkg::*;
    logic sys_clk_i = 1'b0;
    logic nrst_i = 1'b0;
    logic sclk, sync_n, sdi, sdo, alert_n, trst;
    logic hot = 1'b0;
    logic crit = 1'b0;
    logic rdy = 1'b0;
    logic [SUP_W-1:0] sup = '0;
    logic [3:0] din = 4'h0;
    logic [31:0] seed = 32'hdb786f5f;
    logic [31:0] r;
    logic [127:0] rx;
    logic [7:0] m;
    int err_total = 0;
    int n_compared = 0;
    int n_trst = 0;

    always #10 sys_clk_i = ~sys_clk_i;
    always @(posedge sys_clk_i) if (trst === 1'b1) n_trst <= n_trst + 1;

    csa_spi_port dut (.sys_clk_i(sys_clk_i), .nrst_i(nrst_i), .sclk_i(sclk),
        .sync_n_i(sync_n), .sdi_i(sdi), .sdo_o(sdo), .alert_n_o(alert_n),
        .die_hot_i(hot), .die_crit_i(crit), .supply_low_i(sup), .adc_rdy_i(rdy),
        .din_comp_i(din), .thermal_reset_o(trst));
    csa_host_model host (.sys_clk_i(sys_clk_i), .sclk_o(sclk), .sync_n_o(sync_n),
        .sdi_o(sdi), .sdo_i(sdo));

    // ****************************************
    // Helpers
    // ****************************************
    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction : rnd

    function automatic logic [31:0] frame(input logic [6:0] a, input logic [15:0] d);
        return {1'b0, a, d, host.crc8({1'b0, a, d})};
    endfunction : frame

    function automatic logic [31:0] exp_word(input logic [6:0] h, input logic [15:0] d);
        return {1'b1, h, d, host.crc8({1'b1, h, d})};
    endfunction : exp_word

    task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
        n_compared++;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", what, exp, got);
            err_total++;
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge sys_clk_i);
        #1;
    endtask : tick

    task automatic alert_is(input logic e);
        chk("alert pin", {31'h0, e}, {31'h0, alert_n});
    endtask : alert_is

    task automatic wr(input logic [6:0] a, input logic [15:0] d);
        host.xfer(frame(a, d), 32, rnd(), rx);
    endtask : wr

    // Select bits: [1] auto readback, [0] info header
    task automatic rd(input logic [6:0] a, input logic [1:0] sel, input logic [6:0] h,
                      input logic [15:0] d);
        wr(ADDR_RD_SEL, {6'h00, sel, 1'b0, a});
        wr(ADDR_NOP, 16'h0000);
        chk("read word", exp_word(h, d), rx[31:0]);
    endtask : rd

    task automatic test_done();
        $display("compared %0d mismatches %0d", n_compared, err_total);
        if (err_total == 0 && n_compared > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask : test_done

    // ****************************************
    // Scenarios
    // ****************************************
    initial
    begin
        tick(10);
        nrst_i = 1'b1;
        tick(8);
        alert_is(1'b0);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0001);
        wr(ADDR_STATUS, 16'h0001);
        alert_is(1'b1);
        host.xfer(frame(ADDR_MASK, 16'h00ff) ^ 32'h1, 32, 32'h0, rx);
        alert_is(1'b0);
        rd(ADDR_MASK, 2'b00, ADDR_MASK, 16'h0000);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0002);
        wr(ADDR_STATUS, 16'h0002);
        wr(ADDR_MASK, 16'h0006);
        host.xfer(frame(ADDR_MASK, 16'h00ff) ^ 32'h100, 32, 32'h0, rx);
        alert_is(1'b1);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0002);
        wr(ADDR_STATUS, 16'h0002);
        wr(ADDR_MASK, 16'h0000);
        for (int n = 31; n <= 33; n += 2)
        begin
            host.xfer(frame(ADDR_MASK, 16'h00aa), n, rnd(), rx);
            alert_is(1'b0);
            rd(ADDR_MASK, 2'b00, ADDR_MASK, 16'h0000);
            rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0004);
            wr(ADDR_STATUS, 16'h0004);
        end
        for (int k = 0; k < 4; k++)
        begin
            r = rnd();
            din = r[3:0];
            rdy = r[4];
            m = r[15:8];
            wr(ADDR_MASK, {8'h00, m});
            rd(ADDR_MASK, {1'b0, r[5]}, r[5] ? {2'b00, rdy, din} : ADDR_MASK,
               {8'h00, m});
        end
        wr(ADDR_MASK, 16'h005a);
        wr(ADDR_RD_SEL, {9'h000, ADDR_MASK});
        host.xfer(frame(ADDR_MASK, 16'h00c3), 80, rnd(), rx);
        chk("stream word0", exp_word(ADDR_MASK, 16'h005a), rx[79:48]);
        r = exp_word(ADDR_STATUS, 16'h0000);
        chk("stream word1", {8'h00, r[23:0]}, {8'h00, rx[47:24]});
        r = exp_word(ADDR_LIVE, 16'h0000);
        chk("stream word2", {8'h00, r[23:0]}, {8'h00, rx[23:0]});
        alert_is(1'b1);
        rd(ADDR_MASK, 2'b00, ADDR_MASK, 16'h005a);
        wr(ADDR_RD_SEL, {9'h000, ADDR_MASK});
        host.xfer(frame(ADDR_NOP, 16'h0000), 42, rnd(), rx);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0004);
        wr(ADDR_STATUS, 16'h0004);
        wr(ADDR_RD_SEL, {6'h00, 2'b10, 1'b0, ADDR_MASK});
        for (int k = 0; k < 2; k++)
        begin
            wr(ADDR_NOP, 16'h0000);
            chk("auto word", exp_word(ADDR_MASK, 16'h005a), rx[31:0]);
        end
        wr(ADDR_RD_SEL, 16'h0000);
        wr(ADDR_MASK, 16'h0000);
        r = rnd();
        sup = 4'h1 << r[1:0];
        hot = 1'b1;
        tick(10);
        alert_is(1'b0);
        rd(ADDR_LIVE, 2'b00, ADDR_LIVE, {8'h00, sup, 4'h8});
        hot = 1'b0;
        sup = '0;
        tick(10);
        rd(ADDR_LIVE, 2'b00, ADDR_LIVE, 16'h0000);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, {8'h00, 4'h1 << r[1:0], 4'h8});
        wr(ADDR_STATUS, 16'h00ff);
        alert_is(1'b1);
        crit = 1'b1;
        tick(20);
        chk("thermal resets", 32'h0, n_trst);
        crit = 1'b0;
        wr(ADDR_THERM, 16'h0001);
        crit = 1'b1;
        tick(20);
        chk("thermal resets", 32'h1, n_trst);
        crit = 1'b0;
        tick(10);
        alert_is(1'b0);
        rd(ADDR_STATUS, 2'b00, ADDR_STATUS, 16'h0001);
        test_done();
    end

    initial
    begin
        #800000;
        err_total++;
        test_done();
    end
endmodule : csa_spi_port_tb_top
`default_nettype wire
